/* File: logic/iq_framer_pkg.sv */
// Constants, register layout and state types for the I/Q serial output framer
package iq_framer_pkg;
    // Register addresses on the control port
    localparam logic [7:0] CTRL_ADDR = 8'h22;
    localparam logic [7:0] STATUS_ADDR = 8'h23;
    // Field positions in serial_output_control
    localparam int SPLIT_BIT = 7;
    localparam int MODE_HI = 6;
    localparam int MODE_LO = 5;
    localparam int LEN_BIT = 4;
    localparam int MASTER_BIT = 3;
    localparam int DIV_HI = 2;
    localparam int DIV_LO = 0;
    // Slave operation, 16-bit words, combined output after reset
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Frame sync generation modes
    localparam logic [1:0] FS_MODE_ONE = 2'b00;
    localparam logic [1:0] FS_MODE_PAIR = 2'b01;
    localparam logic [1:0] FS_MODE_WORD = 2'b10;
    localparam logic [1:0] FS_MODE_HOLD = 2'b11;
    // Word geometry
    localparam int WORD_W = 24;
    localparam logic [4:0] LEN_SHORT_M1 = 5'd15;
    localparam logic [4:0] LEN_LONG_M1 = 5'd23;
    localparam int FRAME_WORDS = 4;
    localparam int FIFO_DEPTH = 32;
    // Shortest serial clock period less one, in device clocks, used when the divider reads zero
    localparam logic [2:0] DIV_MIN_M1 = 3'd1;
    // Clock rates: device clock and the far party's serial clock ceiling
    localparam int CLK_HZ = 25000000;
    localparam int SCLK_MAX_HZ = 52000000;
    // Frame sequencer states
    typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT} frame_state_t;
endpackage : iq_framer_pkg

/* File: logic/iq_serial_output_framer.sv */
// Serial I/Q output port: frame buffer, clock divider, frame sync modes and bit shifter
// Operation
// - Master drives clock and sync; slave takes both
// - Outputs change on rise; sync sampled on fall
// - I MSB first, through to Q LSB
// - Data outputs released outside own slot
// - Slave waits for sync, then drives I
// - Control bit 4 picks 16 or 24 bits
// - Bit 7 splits channels over two outputs
// - Bits 6 to 5 select sync mode
// - Split, mode 00/01: one common pulse
// - Split, mode 10: pulse before I and Q
// - Split, mode 11: sync held through words
// - Combined, mode 00: one pulse, four words
// - Combined, mode 01: pulse per channel pair
// - Combined, mode 10: pulse before every word
// - Combined, mode 11: sync held all four words
// - Master starts sync when buffer loaded
// - Serial clock is device clock over divider+1, zero acting as one
// - Data ready marks a frame waiting
// - Reset leaves the port in slave operation
`timescale 1ns/100ps
module iq_serial_output_framer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    input wire logic [iq_framer_pkg::WORD_W-1:0] word_in_data,
    input wire logic word_in_valid,
    output logic word_in_ready,
    input wire logic serial_clock_in,
    output logic serial_clock_out,
    output logic serial_clock_oe,
    input wire logic frame_sync_in,
    output logic frame_sync_out,
    output logic frame_sync_oe,
    output logic serial_data_out_first,
    output logic serial_data_out_first_oe,
    output logic serial_data_out_second,
    output logic serial_data_out_second_oe,
    output logic data_ready_pin
);
    import iq_framer_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    logic [7:0] ctrl_r, ctrl_nxt, rd_data_r, rd_data_nxt;
    logic master, split, hold_mode;
    logic [1:0] fs_mode;
    logic [2:0] serial_clock_divider;
    logic [4:0] len_m1;
    logic [1:0] last_word;

    // Control register; reset value keeps the port a slave
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (reg_wr_en && (reg_addr == CTRL_ADDR)) begin
            ctrl_nxt = reg_wr_data;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Fields are read live; rewriting them mid-frame changes the frame in flight
    assign master = ctrl_r[MASTER_BIT];
    assign split = ctrl_r[SPLIT_BIT];
    assign fs_mode = ctrl_r[MODE_HI:MODE_LO];
    assign hold_mode = (fs_mode == FS_MODE_HOLD);
    assign serial_clock_divider = ctrl_r[DIV_HI:DIV_LO];
    assign len_m1 = ctrl_r[LEN_BIT] ? LEN_LONG_M1 : LEN_SHORT_M1;
    assign last_word = split ? 2'd1 : 2'd3;

    // Master clock divider and slave pin synchronisers
    logic [2:0] period_m1;
    logic [3:0] fall_cnt;
    logic [2:0] div_cnt_r, div_cnt_nxt;
    logic sclk_r, sclk_nxt;
    logic sclk_s1_r, sclk_s2_r, sclk_s3_r, sclk_lvl_r, sclk_lvl_nxt;
    logic fs_s1_r, fs_s2_r, fs_s3_r, fs_lvl_r, fs_lvl_nxt;
    logic rise_evt, fall_evt, fs_now;

    // A divider of zero cannot toggle a pin at the device rate, so it runs at half rate
    assign period_m1 = (serial_clock_divider == 3'd0) ? DIV_MIN_M1 : serial_clock_divider;
    assign fall_cnt = (({1'b0, period_m1} + 4'd1) >> 1) - 4'd1;
    // Slave edges count once the second and third stages agree
    assign sclk_lvl_nxt = (sclk_s2_r == sclk_s3_r) ? sclk_s2_r : sclk_lvl_r;
    assign fs_lvl_nxt = (fs_s2_r == fs_s3_r) ? fs_s2_r : fs_lvl_r;
    assign fs_now = fs_lvl_nxt;
    assign rise_evt = master ? (div_cnt_r == period_m1) : (sclk_lvl_nxt && !sclk_lvl_r);
    assign fall_evt = master ? (div_cnt_r == fall_cnt[2:0]) : (!sclk_lvl_nxt && sclk_lvl_r);

    always_comb begin
        div_cnt_nxt = 3'd0;
        sclk_nxt = 1'b0;
        if (master) begin
            div_cnt_nxt = (div_cnt_r == period_m1) ? 3'd0 : div_cnt_r + 3'd1;
            sclk_nxt = rise_evt ? 1'b1 : (fall_evt ? 1'b0 : sclk_r);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt_r <= 3'd0;
            sclk_r <= 1'b0;
            sclk_s1_r <= 1'b0;
            sclk_s2_r <= 1'b0;
            sclk_s3_r <= 1'b0;
            sclk_lvl_r <= 1'b0;
            fs_s1_r <= 1'b0;
            fs_s2_r <= 1'b0;
            fs_s3_r <= 1'b0;
            fs_lvl_r <= 1'b0;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            sclk_r <= sclk_nxt;
            sclk_s1_r <= serial_clock_in;
            sclk_s2_r <= sclk_s1_r;
            sclk_s3_r <= sclk_s2_r;
            sclk_lvl_r <= sclk_lvl_nxt;
            fs_s1_r <= frame_sync_in;
            fs_s2_r <= fs_s1_r;
            fs_s3_r <= fs_s2_r;
            fs_lvl_r <= fs_lvl_nxt;
        end
    end

    assign serial_clock_out = sclk_r;
    assign serial_clock_oe = master;
    assign frame_sync_oe = master;

    // Frame buffer filled from the FIFO, AI, AQ, BI, BQ in that order
    logic [WORD_W-1:0] fifo_data;
    logic fifo_valid, fifo_ready;
    logic [WORD_W-1:0] buf_r [0:FRAME_WORDS-1];
    logic [WORD_W-1:0] buf_nxt [0:FRAME_WORDS-1];
    logic [1:0] load_idx_r, load_idx_nxt;
    logic buf_full_r, buf_full_nxt;
    frame_state_t st_r, st_nxt;
    logic frame_done;

    sample_fifo #(
        .WIDTH(WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_data(word_in_data),
        .in_valid(word_in_valid),
        .in_ready(word_in_ready),
        .out_data(fifo_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_ready)
    );

    // no loading while a frame is out
    assign fifo_ready = !buf_full_r && (st_r == ST_IDLE);
    assign data_ready_pin = buf_full_r && (st_r == ST_IDLE);

    always_comb begin
        buf_nxt = buf_r;
        load_idx_nxt = load_idx_r;
        buf_full_nxt = buf_full_r;
        if (frame_done) begin
            buf_full_nxt = 1'b0;
        end else if (fifo_valid && fifo_ready) begin
            buf_nxt[load_idx_r] = fifo_data;
            load_idx_nxt = load_idx_r + 2'd1;
            buf_full_nxt = (load_idx_r == 2'd3);
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < FRAME_WORDS; i++) begin
                buf_r[i] <= '0;
            end
            load_idx_r <= 2'd0;
            buf_full_r <= 1'b0;
        end else begin
            buf_r <= buf_nxt;
            load_idx_r <= load_idx_nxt;
            buf_full_r <= buf_full_nxt;
        end
    end

    // Which words get a one-clock sync pulse ahead of them
    function automatic logic pulse_before(input logic [1:0] w, input logic sp, input logic [1:0] m);
        logic r;
        r = (w == 2'd0);
        if (sp) begin
            if (m == FS_MODE_WORD) r = (w <= 2'd1);
        end else begin
            if (m == FS_MODE_PAIR) r = (w == 2'd0) || (w == 2'd2);
            if (m == FS_MODE_WORD) r = 1'b1;
        end
        return r;
    endfunction : pulse_before

    // Frame sequencer and bit shifter
    logic [4:0] bit_r, bit_nxt, pick;
    logic [1:0] word_r, word_nxt, w_sel;
    logic [4:0] b_sel;
    logic data0_r, data0_nxt, data1_r, data1_nxt, oe0_r, oe0_nxt, oe1_r, oe1_nxt;
    logic fs_r, fs_nxt, armed_r, armed_nxt, load_bit;

    assign frame_done = rise_evt && (st_r == ST_SHIFT) && (bit_r == len_m1) && (word_r == last_word);

    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        word_nxt = word_r;
        data0_nxt = data0_r;
        data1_nxt = data1_r;
        oe0_nxt = oe0_r;
        oe1_nxt = oe1_r;
        fs_nxt = fs_r;
        armed_nxt = armed_r;
        load_bit = 1'b0;
        w_sel = 2'd0;
        b_sel = 5'd0;
        pick = 5'd0;
        // slave sync sampled on falling edge
        if (!master && fall_evt && (st_r == ST_IDLE)) begin
            armed_nxt = fs_now;
        end
        if (master) begin
            armed_nxt = 1'b0;
        end
        // everything moves on the rising edge
        if (rise_evt) begin
            case (st_r)
                ST_IDLE: begin
                    if (master && buf_full_r) begin
                        st_nxt = ST_LEAD;
                        fs_nxt = 1'b1;
                    end else if (!master && armed_r) begin
                        st_nxt = ST_SHIFT;
                        armed_nxt = 1'b0;
                        load_bit = 1'b1;
                    end
                end
                ST_LEAD: begin
                    st_nxt = ST_SHIFT;
                    load_bit = 1'b1;
                end
                ST_SHIFT: begin
                    if (frame_done) begin
                        st_nxt = ST_IDLE;
                        oe0_nxt = 1'b0;
                        oe1_nxt = 1'b0;
                        data0_nxt = 1'b0;
                        data1_nxt = 1'b0;
                        fs_nxt = 1'b0;
                    end else begin
                        load_bit = 1'b1;
                        w_sel = (bit_r == len_m1) ? word_r + 2'd1 : word_r;
                        b_sel = (bit_r == len_m1) ? 5'd0 : bit_r + 5'd1;
                    end
                end
                default: begin
                    st_nxt = ST_IDLE;
                end
            endcase
        end
        if (load_bit) begin
            bit_nxt = b_sel;
            word_nxt = w_sel;
            pick = len_m1 - b_sel;
            data0_nxt = buf_r[w_sel][pick];
            data1_nxt = buf_r[w_sel + 2'd2][pick];
            oe0_nxt = 1'b1;
            oe1_nxt = split;
            // single leading pulse is the default word-0 case
            fs_nxt = master && (hold_mode || ((b_sel == len_m1) && (w_sel != last_word)
                     && pulse_before(w_sel + 2'd1, split, fs_mode)));
            if (master && hold_mode) fs_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= ST_IDLE;
            bit_r <= 5'd0;
            word_r <= 2'd0;
            data0_r <= 1'b0;
            data1_r <= 1'b0;
            oe0_r <= 1'b0;
            oe1_r <= 1'b0;
            fs_r <= 1'b0;
            armed_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            word_r <= word_nxt;
            data0_r <= data0_nxt;
            data1_r <= data1_nxt;
            oe0_r <= oe0_nxt;
            oe1_r <= oe1_nxt;
            fs_r <= fs_nxt;
            armed_r <= armed_nxt;
        end
    end

    assign frame_sync_out = fs_r;
    assign serial_data_out_first = data0_r;
    assign serial_data_out_first_oe = oe0_r;
    assign serial_data_out_second = data1_r;
    assign serial_data_out_second_oe = oe1_r;

    // Read port: registered, unmapped addresses read zero
    always_comb begin
        rd_data_nxt = 8'h00;
        if (reg_addr == CTRL_ADDR) begin
            rd_data_nxt = ctrl_r;
        end else if (reg_addr == STATUS_ADDR) begin
            rd_data_nxt = {5'h00, fifo_valid, buf_full_r, (st_r != ST_IDLE)};
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_data_r <= 8'h00;
        end else begin
            rd_data_r <= rd_data_nxt;
        end
    end
    assign reg_rd_data = rd_data_r;

    // Checks on the sequencer
    pin_direction_a: assert property (serial_clock_oe == ctrl_r[MASTER_BIT] && frame_sync_oe == serial_clock_oe)
        else $error("clock and sync direction disagree with master select");
    rise_only_a: assert property (!$past(rise_evt) |-> $stable(data0_r) && $stable(fs_r))
        else $error("serial output moved without a rising edge");
    msb_first_a: assert property ((rise_evt && st_r == ST_LEAD) |=> data0_r == $past(buf_r[0][len_m1]))
        else $error("first bit is not the I word MSB");
    slot_release_a: assert property ($fell(oe0_r) |-> st_r == ST_IDLE && $past(frame_done))
        else $error("data driver released outside frame end");
    slave_start_a: assert property ((!master && armed_r && rise_evt && st_r == ST_IDLE) |=> oe0_r && st_r == ST_SHIFT)
        else $error("slave did not start after sync");
    word_length_a: assert property (st_r == ST_SHIFT |-> bit_r <= len_m1)
        else $error("bit count past word length");
    hold_sync_a: assert property ((master && hold_mode && st_r != ST_IDLE) |-> fs_r)
        else $error("held sync dropped inside frame");
    master_start_a: assert property ((master && st_r == ST_IDLE && buf_full_r && rise_evt) |=> st_r == ST_LEAD && fs_r)
        else $error("master did not raise sync on loaded buffer");
    divider_a: assert property ((master && rise_evt && $stable(ctrl_r)) |=> !rise_evt)
        else $error("serial clock rises on consecutive device clocks");
    ready_drop_a: assert property (st_r != ST_IDLE |-> !data_ready_pin)
        else $error("data ready high during transfer");
endmodule : iq_serial_output_framer

/* File: logic/sample_fifo.sv */
// Word FIFO with a registered head stage, valid/ready on both sides
`timescale 1ns/100ps
module sample_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wr_ptr_r, wr_ptr_nxt, rd_ptr_r, rd_ptr_nxt;
    logic [AW:0] count_r, count_nxt;
    logic [WIDTH-1:0] head_r, head_nxt;
    logic head_vld_r, head_vld_nxt;
    logic push, refill;

    // Back-pressure: refuse words once the array is full
    assign in_ready = (count_r != FULL_COUNT);
    assign push = in_valid && in_ready;
    // Head stage refills when empty or being drained
    assign refill = (count_r != '0) && (!head_vld_r || out_ready);
    assign out_data = head_r;
    assign out_valid = head_vld_r;

    // Pointer, count and head next values; pointers wrap, so DEPTH must be a power of two
    always_comb begin
        wr_ptr_nxt = push ? wr_ptr_r + 1'b1 : wr_ptr_r;
        rd_ptr_nxt = refill ? rd_ptr_r + 1'b1 : rd_ptr_r;
        count_nxt = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, refill};
        head_nxt = head_r;
        head_vld_nxt = head_vld_r;
        if (refill) begin
            head_nxt = mem[rd_ptr_r];
            head_vld_nxt = 1'b1;
        end else if (out_ready) begin
            head_vld_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            head_r <= '0;
            head_vld_r <= 1'b0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
            head_r <= head_nxt;
            head_vld_r <= head_vld_nxt;
        end
    end

    // Storage array carries no reset; only the count says what is valid
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_r] <= in_data;
        end
    end
endmodule : sample_fifo

/* File: verif/dsp_rx_model.sv */
// Behavioural DSP serial receive port facing the framer
`timescale 1ns/100ps
module dsp_rx_model (
    input wire logic serial_clock_out,
    input wire logic serial_clock_oe,
    input wire logic frame_sync_out,
    input wire logic frame_sync_oe,
    input wire logic serial_data_out_first,
    input wire logic serial_data_out_first_oe,
    input wire logic serial_data_out_second,
    input wire logic serial_data_out_second_oe,
    output logic serial_clock_in,
    output logic frame_sync_in
);
    // Slave half period; slow because the port oversamples our clock
    localparam time HALF_NS = 320;
    logic sclk_drv = 1'b0;
    logic fs_drv = 1'b0;
    logic [95:0] first_sr = '0;
    logic [95:0] second_sr = '0;
    int n_bits = 0;
    int n_sync = 0;

    // Pin levels from whichever side drives each line
    assign serial_clock_in = serial_clock_oe ? serial_clock_out : sclk_drv;
    assign frame_sync_in = frame_sync_oe ? frame_sync_out : fs_drv;

    always @(negedge serial_clock_in) begin
        if (frame_sync_in) n_sync++;
        if (serial_data_out_first_oe) begin
            first_sr = {first_sr[94:0], serial_data_out_first};
            n_bits++;
        end
        if (serial_data_out_second_oe) second_sr = {second_sr[94:0], serial_data_out_second};
    end

    // Forget everything seen so far
    task automatic clear();
        n_bits = 0;
        n_sync = 0;
        first_sr = '0;
        second_sr = '0;
    endtask : clear

    // slow slave clock; clock stands low between frames
    task automatic slave_frame(input int n);
        fs_drv = 1'b1;
        #HALF_NS sclk_drv = 1'b1;
        #HALF_NS sclk_drv = 1'b0;
        #HALF_NS sclk_drv = 1'b1;
        fs_drv = 1'b0;
        repeat (n) begin
            #HALF_NS sclk_drv = 1'b0;
            #HALF_NS sclk_drv = 1'b1;
        end
        #HALF_NS sclk_drv = 1'b0;
    endtask : slave_frame
endmodule : dsp_rx_model

/* File: verif/iq_serial_output_framer_test.sv */
// Self-checking bench for the I/Q serial output framer
`timescale 1ns/100ps
module iq_serial_output_framer_test;
    import iq_framer_pkg::*;
    logic clk;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr_en = 1'b0;
    logic [7:0] reg_wr_data = 8'h00;
    logic [7:0] reg_rd_data;
    logic [23:0] word_in_data = 24'h000000;
    logic word_in_valid = 1'b0;
    logic word_in_ready;
    logic serial_clock_in, serial_clock_out, serial_clock_oe;
    logic frame_sync_in, frame_sync_out, frame_sync_oe;
    logic serial_data_out_first, serial_data_out_first_oe;
    logic serial_data_out_second, serial_data_out_second_oe;
    logic data_ready_pin;
    logic [23:0] words [4] = '{24'h9a5c31, 24'h4e17b2, 24'hc3a965, 24'h07f18d};
    int divs [3] = '{0, 3, 7};
    int n_fail = 0;
    int compares = 0;
    logic [7:0] rd;
    logic ok;
    int acc;
    time t0;

    iq_serial_output_framer dut_u (.clk, .sys_rst, .reg_addr, .reg_wr_en, .reg_wr_data, .reg_rd_data,
        .word_in_data, .word_in_valid, .word_in_ready, .serial_clock_in, .serial_clock_out, .serial_clock_oe,
        .frame_sync_in, .frame_sync_out, .frame_sync_oe, .serial_data_out_first, .serial_data_out_first_oe,
        .serial_data_out_second, .serial_data_out_second_oe, .data_ready_pin);

    dsp_rx_model partner_u (.serial_clock_out, .serial_clock_oe, .frame_sync_out, .frame_sync_oe,
        .serial_data_out_first, .serial_data_out_first_oe, .serial_data_out_second,
        .serial_data_out_second_oe, .serial_clock_in, .frame_sync_in);

    // 25 MHz device clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic check(input logic [95:0] got, input logic [95:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("Compares %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wr_data <= d;
        reg_wr_en <= 1'b1;
        @(posedge clk);
        reg_wr_en <= 1'b0;
    endtask : reg_write

    // Read data is registered, so hold the address across two edges
    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        repeat (2) @(posedge clk);
        #1 d = reg_rd_data;
    endtask : reg_read

    // Offer one word; gives up after a few cycles so refusal can be seen
    task automatic push(input logic [23:0] w, output logic took);
        took = 1'b0;
        @(posedge clk);
        word_in_data <= w;
        word_in_valid <= 1'b1;
        for (int i = 0; i < 8 && !took; i++) begin
            @(posedge clk);
            took = (word_in_ready === 1'b1);
        end
        word_in_valid <= 1'b0;
    endtask : push

    // Words of the table, trimmed to the word length, first word leftmost
    function automatic logic [95:0] pack(input int nw, input int lo, input int cnt);
        logic [95:0] v;
        v = '0;
        for (int k = lo; k < lo + cnt; k++) v = (v << nw) | 96'(words[k] & ((24'h1 << nw) - 24'h1));
        return v;
    endfunction : pack

    // Serial periods per frame in which sync is seen high
    function automatic int exp_sync(input logic split, input logic [1:0] mode, input int nw);
        case (mode)
            FS_MODE_HOLD: return 1 + (split ? 2 : 4) * nw;
            FS_MODE_WORD: return split ? 2 : 4;
            FS_MODE_PAIR: return split ? 1 : 2;
            default: return 1;
        endcase
    endfunction : exp_sync

    // One master frame with the given control value
    task automatic run_frame(input logic [7:0] ctrl);
        int nw;
        int nb;
        logic took;
        nw = ctrl[LEN_BIT] ? 24 : 16;
        nb = (ctrl[SPLIT_BIT] ? 2 : 4) * nw;
        partner_u.clear();
        reg_write(CTRL_ADDR, ctrl);
        for (int k = 0; k < 4; k++) push(words[k], took);
        for (int i = 0; i < 4000 && partner_u.n_bits < nb; i++) @(posedge clk);
        repeat (8) @(posedge clk);
        check(96'(partner_u.n_bits), 96'(nb));
        check(96'(partner_u.n_sync), 96'(exp_sync(ctrl[SPLIT_BIT], ctrl[MODE_HI:MODE_LO], nw)));
        check(partner_u.first_sr, ctrl[SPLIT_BIT] ? pack(nw, 0, 2) : pack(nw, 0, 4));
        check(partner_u.second_sr, ctrl[SPLIT_BIT] ? pack(nw, 2, 2) : 96'h0);
        check(96'({serial_data_out_first_oe, serial_data_out_second_oe}), 96'h0);
    endtask : run_frame

    // Hang guard, well beyond the expected run of about 4k cycles
    initial begin
        #2000000;
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (6) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset state and register map
        reg_read(CTRL_ADDR, rd);
        check(96'(rd), 96'(CTRL_RESET));
        check(96'({serial_clock_oe, frame_sync_oe, serial_data_out_first_oe, data_ready_pin}), 96'h0);
        reg_write(CTRL_ADDR, 8'h5a);
        reg_write(STATUS_ADDR, 8'hff);
        reg_write(8'h40, 8'hff);
        reg_read(STATUS_ADDR, rd);
        check(96'(rd), 96'h0);
        reg_read(8'h40, rd);
        check(96'(rd), 96'h0);
        reg_read(CTRL_ADDR, rd);
        check(96'(rd), 96'h5a);
        // Master clock period per divider, zero acting as one
        foreach (divs[j]) begin
            reg_write(CTRL_ADDR, 8'h08 | 8'(divs[j]));
            repeat (2) @(posedge serial_clock_out);
            t0 = $time;
            @(posedge serial_clock_out);
            check(96'($time - t0), 96'(((divs[j] == 0 ? 1 : divs[j]) + 1) * 40));
            check(96'({serial_clock_oe, frame_sync_oe}), 96'h3);
        end
        // Every sync mode on split and combined outputs, then long words
        for (int s = 0; s < 2; s++) begin
            for (int m = 0; m < 4; m++) run_frame({1'(s), 2'(m), 5'b01001});
        end
        run_frame(8'h19);
        // Slave frame clocked in by the partner after data ready
        partner_u.clear();
        reg_write(CTRL_ADDR, CTRL_RESET);
        for (int k = 0; k < 4; k++) push(words[k], ok);
        for (int i = 0; i < 50 && data_ready_pin !== 1'b1; i++) @(posedge clk);
        check(96'(data_ready_pin), 96'h1);
        check(96'(serial_data_out_first_oe), 96'h0);
        partner_u.slave_frame(64);
        repeat (8) @(posedge clk);
        check(partner_u.first_sr, pack(16, 0, 4));
        check(96'(partner_u.n_bits), 96'd64);
        check(96'({data_ready_pin, serial_data_out_first_oe}), 96'h0);
        // Fill until refused while idle, then drain through master frames
        acc = 0;
        ok = 1'b1;
        while (ok && acc < 64) begin
            push(words[acc % 4], ok);
            acc += int'(ok);
        end
        check(96'(acc >= FIFO_DEPTH && word_in_ready === 1'b0), 96'h1);
        // An odd word left over is pulled into the buffer and waits there, so status ends all clear
        partner_u.clear();
        reg_write(CTRL_ADDR, 8'h09);
        for (int i = 0; i < 1000; i++) begin
            reg_read(STATUS_ADDR, rd);
            if (rd === 8'h00 && word_in_ready === 1'b1) break;
        end
        check(96'(rd), 96'h0);
        check(96'(word_in_ready), 96'h1);
        check(96'(data_ready_pin), 96'h0);
        check(96'(partner_u.n_bits), 96'((acc / 4) * 64));
        check(partner_u.first_sr, (pack(16, 2, 2) << 64) | pack(16, 0, 4));
        wrap_up();
    end
endmodule : iq_serial_output_framer_test
